/* logic/ptm_paired_timer.sv */
// Contract
// - each pair runs as two 16-bit timers, one 32-bit timer or counter
// - split halves keep every 16-bit mode except asynchronous counting
// - each 16-bit timer works alone as synchronous timer or counter
// - cascade bit 3 of low control joins the pair into 32 bits
// - in 32-bit mode low timer is low word, high timer high word
// - in 32-bit mode high control is ignored, low control rules all
// - 32-bit mode uses low clock and gate, interrupts on high flag
// - two-bit prescale field picks the prescaler ratio
// - source bit picks internal or external clock, gate bit gates timing
// - high period holds upper word, low period lower word in 32-bit
// - 32-bit count always readable, high count holds upper word
// - in 16-bit mode each timer compares with its own period
// - cascade pair interrupts when 32-bit count matches 32-bit period
// - a timer counts only while its on bit 15 is set
// - converter trigger only from first pair cascade or its high timer
// - timers may keep running in idle and sleep
// - cascade interrupt enable and priority come from the high timer
// - priority codes 7 down to 1, code 0 disables the source
// - every priority field resets to level 4
//
// Decided for this implementation: register access over Avalon-MM and the address map.
module ptm_paired_timer
   import ptm_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [3:0] external_timer_clock_in,
   input wire logic idle_mode,
   output logic [3:0] irq_request,
   output logic [11:0] irq_priority,
   output logic adc_trigger
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [3:0][15:0] ctrl;
      logic [3:0][15:0] period;
      logic [3:0] flag;
      logic [3:0] ien;
      logic [3:0][2:0] prio;
      logic [3:0] pin_s1;
      logic [3:0] pin_s2;
      logic [3:0] pin_s3;
      logic waitreq;
      logic [31:0] rdata;
      logic [3:0] irq;
      logic adc;
   } ptm_top_s;

   ptm_top_s s_reg;
   ptm_top_s s_next;

   logic [3:0] tmr_run;
   logic [3:0] tmr_inc;
   logic [3:0] tmr_zero;
   logic [3:0] tmr_event;
   logic [3:0] tmr_wr;
   logic [3:0] tmr_tick;
   logic [3:0][15:0] tmr_count;
   logic [3:0] ext_rise;

   // ----------------------------------------------------------------
   // four timer halves
   // ----------------------------------------------------------------
   assign ext_rise = s_reg.pin_s2 & ~s_reg.pin_s3;

   for (genvar i = 0; i < PTM_NUM_TIMERS; i++) begin : g_half
      ptm_half u_half (
         .clk(clk),
         .reset_n(reset_n),
         .run(tmr_run[i]),
         .src_ext(s_reg.ctrl[i][BIT_CLOCK_SOURCE]),
         .gate_en(s_reg.ctrl[i][BIT_GATE_ENABLE]),
         .prescale_sel(s_reg.ctrl[i][BIT_PRESCALE_HI:BIT_PRESCALE_LO]),
         .ext_rise(ext_rise[i]),
         .ext_level(s_reg.pin_s2[i]),
         .inc(tmr_inc[i]),
         .zero(tmr_zero[i]),
         .count_wr(tmr_wr[i]),
         .wr_data(avs_writedata[15:0]),
         .tick(tmr_tick[i]),
         .count(tmr_count[i])
      );
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [31:0] cnt32;
      logic [31:0] per32;
      logic [31:0] rd;
      logic m32;
      logic casc;
      logic acc_req;
      logic start;
      logic done_wr;
      logic [3:0] flag_clr;
      int lo;
      int hi;
      cnt32 = 32'h0000_0000;
      per32 = 32'h0000_0000;
      rd = 32'h0000_0000;
      m32 = 1'b0;
      casc = 1'b0;
      acc_req = avs_read || avs_write;
      start = acc_req && s_reg.waitreq;
      done_wr = avs_write && !s_reg.waitreq;
      flag_clr = 4'h0;
      lo = 0;
      hi = 0;
      s_next = s_reg;
      tmr_run = 4'h0;
      tmr_inc = 4'h0;
      tmr_zero = 4'h0;
      tmr_event = 4'h0;
      tmr_wr = 4'h0;

      // --------------------------------------------------------------
      // pin synchronisers
      // --------------------------------------------------------------
      s_next.pin_s1 = external_timer_clock_in;
      s_next.pin_s2 = s_reg.pin_s1;
      s_next.pin_s3 = s_reg.pin_s2;

      // --------------------------------------------------------------
      // pair counting
      // --------------------------------------------------------------
      for (int p = 0; p < 2; p++) begin
         lo = 2 * p;
         hi = 2 * p + 1;
         casc = s_reg.ctrl[lo][BIT_CASCADE_SELECT];
         cnt32 = {tmr_count[hi], tmr_count[lo]};
         per32 = {s_reg.period[hi], s_reg.period[lo]};
         m32 = (cnt32 == per32);
         // idle stops a timer only on request, sleep never does
         tmr_run[lo] = s_reg.ctrl[lo][BIT_TIMER_ON] &&
            !(idle_mode && s_reg.ctrl[lo][BIT_STOP_IN_IDLE]);
         if (casc) begin
            // high control ignored, high prescaler idles
            tmr_run[hi] = 1'b0;
            tmr_inc[lo] = tmr_tick[lo];
            tmr_zero[lo] = m32;
            tmr_inc[hi] = tmr_tick[lo] &&
               (m32 || tmr_count[lo] == COUNT_MAX);
            tmr_zero[hi] = m32;
            tmr_event[hi] = tmr_tick[lo] && m32;
         end else begin
            tmr_run[hi] = s_reg.ctrl[hi][BIT_TIMER_ON] &&
               !(idle_mode && s_reg.ctrl[hi][BIT_STOP_IN_IDLE]);
            for (int k = lo; k <= hi; k++) begin
               tmr_inc[k] = tmr_tick[k];
               tmr_zero[k] = (tmr_count[k] == s_reg.period[k]);
               tmr_event[k] = tmr_tick[k] && tmr_zero[k];
            end
         end
      end

      // --------------------------------------------------------------
      // read mux
      // --------------------------------------------------------------
      if (avs_address < ADDR_PERIOD_BASE) begin
         rd[15:0] = s_reg.ctrl[avs_address[1:0]];
      end else if (avs_address < ADDR_COUNT_BASE) begin
         rd[15:0] = s_reg.period[avs_address[1:0]];
      end else if (avs_address < ADDR_IRQ_FLAG) begin
         rd[15:0] = tmr_count[avs_address[1:0]];
      end else if (avs_address == ADDR_IRQ_FLAG) begin
         rd[3:0] = s_reg.flag;
      end else if (avs_address == ADDR_IRQ_ENABLE) begin
         rd[3:0] = s_reg.ien;
      end else if (avs_address == ADDR_IRQ_PRIORITY) begin
         for (int i = 0; i < PTM_NUM_TIMERS; i++) begin
            rd[i * PRIO_FIELD_STRIDE +: 3] = s_reg.prio[i];
         end
      end

      // --------------------------------------------------------------
      // bus handshake: one wait cycle, then completion
      // --------------------------------------------------------------
      s_next.waitreq = !start;
      if (start && avs_read) begin
         s_next.rdata = rd;
      end

      // --------------------------------------------------------------
      // register writes at the completion edge
      // --------------------------------------------------------------
      if (done_wr) begin
         if (avs_address < ADDR_PERIOD_BASE) begin
            s_next.ctrl[avs_address[1:0]] = avs_writedata[15:0] &
               (avs_address[0] ? CTRL_MASK_HIGH : CTRL_MASK_LOW);
         end else if (avs_address < ADDR_COUNT_BASE) begin
            s_next.period[avs_address[1:0]] = avs_writedata[15:0];
         end else if (avs_address < ADDR_IRQ_FLAG) begin
            tmr_wr[avs_address[1:0]] = 1'b1;
         end else if (avs_address == ADDR_IRQ_FLAG) begin
            flag_clr = avs_writedata[3:0];
         end else if (avs_address == ADDR_IRQ_ENABLE) begin
            s_next.ien = avs_writedata[3:0];
         end else if (avs_address == ADDR_IRQ_PRIORITY) begin
            for (int i = 0; i < PTM_NUM_TIMERS; i++) begin
               s_next.prio[i] = avs_writedata[i * PRIO_FIELD_STRIDE +: 3];
            end
         end
      end

      // --------------------------------------------------------------
      // flags, interrupt requests, converter trigger
      // --------------------------------------------------------------
      s_next.flag = (s_reg.flag & ~flag_clr) | tmr_event;
      for (int i = 0; i < PTM_NUM_TIMERS; i++) begin
         s_next.irq[i] = s_next.flag[i] && s_reg.ien[i] &&
            (s_reg.prio[i] != PRIO_DISABLED);
      end
      s_next.adc = tmr_event[1];
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_reg <= '0;
         s_reg.ctrl <= {PTM_NUM_TIMERS{CTRL_RESET}};
         s_reg.period <= {PTM_NUM_TIMERS{PERIOD_RESET}};
         s_reg.prio <= {PTM_NUM_TIMERS{PRIO_RESET}};
         s_reg.waitreq <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign avs_readdata = s_reg.rdata;
   assign avs_waitrequest = s_reg.waitreq;
   assign irq_request = s_reg.irq;
   assign irq_priority = s_reg.prio;
   assign adc_trigger = s_reg.adc;

endmodule

/* logic/ptm_pkg.sv */
package ptm_pkg;

   // ----------------------------------------------------------------
   // register map, word index on the avalon address
   // ----------------------------------------------------------------
   localparam int PTM_NUM_TIMERS = 4;
   localparam logic [3:0] ADDR_CTRL_BASE = 4'h0;
   localparam logic [3:0] ADDR_PERIOD_BASE = 4'h4;
   localparam logic [3:0] ADDR_COUNT_BASE = 4'h8;
   localparam logic [3:0] ADDR_IRQ_FLAG = 4'hc;
   localparam logic [3:0] ADDR_IRQ_ENABLE = 4'hd;
   localparam logic [3:0] ADDR_IRQ_PRIORITY = 4'he;

   // ----------------------------------------------------------------
   // control register fields
   // ----------------------------------------------------------------
   localparam int BIT_TIMER_ON = 15;
   localparam int BIT_STOP_IN_IDLE = 13;
   localparam int BIT_GATE_ENABLE = 6;
   localparam int BIT_PRESCALE_HI = 5;
   localparam int BIT_PRESCALE_LO = 4;
   localparam int BIT_CASCADE_SELECT = 3;
   localparam int BIT_CLOCK_SOURCE = 1;
   localparam logic [15:0] CTRL_MASK_LOW = 16'ha07a;
   localparam logic [15:0] CTRL_MASK_HIGH = 16'ha072;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] PERIOD_RESET = 16'hffff;
   localparam logic [2:0] PRIO_RESET = 3'h4;
   localparam logic [2:0] PRIO_DISABLED = 3'h0;
   localparam int PRIO_FIELD_STRIDE = 4;

   // ----------------------------------------------------------------
   // prescaler terminal counts: 1:1, 1:8, 1:64, 1:256
   // ----------------------------------------------------------------
   localparam logic [7:0] PS_LIMIT_1 = 8'h00;
   localparam logic [7:0] PS_LIMIT_8 = 8'h07;
   localparam logic [7:0] PS_LIMIT_64 = 8'h3f;
   localparam logic [7:0] PS_LIMIT_256 = 8'hff;
   localparam logic [15:0] COUNT_MAX = 16'hffff;

endpackage

/* logic/ptm_half.sv */
module ptm_half
   import ptm_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic run,
   input wire logic src_ext,
   input wire logic gate_en,
   input wire logic [1:0] prescale_sel,
   input wire logic ext_rise,
   input wire logic ext_level,
   input wire logic inc,
   input wire logic zero,
   input wire logic count_wr,
   input wire logic [15:0] wr_data,
   output logic tick,
   output logic [15:0] count
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] pre;
      logic [15:0] count;
   } ptm_half_s;

   ptm_half_s s_reg;
   ptm_half_s s_next;
   logic [7:0] limit;
   logic base;

   // ----------------------------------------------------------------
   // prescaler and 16-bit counter
   // ----------------------------------------------------------------
   always_comb begin
      s_next = s_reg;
      tick = 1'b0;
      case (prescale_sel)
         2'h0: limit = PS_LIMIT_1;
         2'h1: limit = PS_LIMIT_8;
         2'h2: limit = PS_LIMIT_64;
         2'h3: limit = PS_LIMIT_256;
         default: limit = PS_LIMIT_1;
      endcase
      // external edges, or internal clock optionally gated by the pin level
      base = src_ext ? ext_rise : (gate_en ? ext_level : 1'b1);
      if (!run) begin
         s_next.pre = 8'h00;
      end else if (base) begin
         if (s_reg.pre == limit) begin
            s_next.pre = 8'h00;
            tick = 1'b1;
         end else begin
            s_next.pre = s_reg.pre + 8'h01;
         end
      end
      if (count_wr) begin
         s_next.count = wr_data;
      end else if (inc) begin
         s_next.count = zero ? 16'h0000 : s_reg.count + 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign count = s_reg.count;

endmodule

/* verification/ptm_paired_timer_assertions.sv */
module ptm_chk
   import ptm_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [3:0] irq_request,
   input wire logic [11:0] irq_priority,
   input wire logic adc_trigger
);
   // ----------------------------------------------------------------
   // priority gate helper and properties
   // ----------------------------------------------------------------
   logic [3:0] pnz_next;
   logic [3:0] pnz_reg;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pnz_next[i] = irq_priority[3*i+:3] != PRIO_DISABLED;
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pnz_reg <= 4'hf;
      end else begin
         pnz_reg <= pnz_next;
      end
   end
   default clocking @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   sequence req_seen;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence one_grant;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   bus_grant_a:
      assert property (req_seen |=> one_grant) else $error("access not answered in one cycle");
   wait_idle_a:
      assert property (!avs_read && !avs_write && $past(avs_waitrequest) |-> avs_waitrequest)
      else $error("waitrequest low without request");
   reset_state_a:
      assert property ($rose(reset_n) |-> irq_priority == 12'h924 && irq_request == 4'h0
         && !adc_trigger) else $error("state after reset wrong");
   prio_gate_a:
      assert property ((irq_request & ~(pnz_next | pnz_reg)) == 4'h0)
      else $error("request with priority zero");
   unmapped_zero_a:
      assert property (avs_read && avs_address == 4'hf && !avs_waitrequest |-> avs_readdata == 0)
      else $error("unmapped read not zero");
   upper_zero_a:
      assert property (avs_readdata[31:16] == 16'h0) else $error("upper read bits set");
   trig_irq_a:
      assert property ($rose(irq_request[1]) && !$past(avs_write) && !$past(avs_write, 2)
         && !$past(avs_write, 3) |-> adc_trigger || $past(adc_trigger) || $past(adc_trigger, 2))
      else $error("period event without trigger");
   prio_hold_a:
      assert property (!$past(avs_write) && !$past(avs_write, 2) |-> $stable(irq_priority))
      else $error("priority changed without write");
endmodule
bind ptm_paired_timer ptm_chk i_chk (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .irq_request(irq_request),
   .irq_priority(irq_priority), .adc_trigger(adc_trigger));

/* verification/testbench.sv */
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // stimulus, bus tasks and tests
   // ----------------------------------------------------------------
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [3:0] pin = 4'h0;
   logic idle_mode = 1'b0;
   logic [3:0] irq_request;
   logic [11:0] irq_priority;
   logic adc_trigger;
   logic [31:0] rd;
   logic [31:0] v;
   int n_errors = 0;
   int n_compared = 0;
   int n_trig = 0;
   int t0;
   int r;
   ptm_paired_timer i_ptm_paired_timer (.clk(clk), .reset_n(reset_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .external_timer_clock_in(pin),
      .idle_mode(idle_mode), .irq_request(irq_request), .irq_priority(irq_priority),
      .adc_trigger(adc_trigger));
   initial begin
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      if (adc_trigger === 1'b1) n_trig <= n_trig + 1;
   end
   task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
      avs_address <= a;
      avs_writedata <= {16'h0, d};
      avs_read <= ~w;
      avs_write <= w;
      @(posedge clk);
      // only the watchdog ends a wait that never completes
      while (avs_waitrequest !== 1'b0) begin
         @(posedge clk);
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic cmp(input string s, input logic [31:0] lo, input logic [31:0] hi,
                      input logic [31:0] x);
      n_compared++;
      if ((x >= lo && x <= hi) !== 1'b1) begin
         n_errors++;
         $display("ERROR %s expected %h..%h seen %h", s, lo, hi, x);
      end
   endtask
   task automatic rc(input logic [3:0] a, input logic [31:0] lo, input logic [31:0] hi,
                     input string s);
      bus(1'b0, a, 16'h0);
      cmp(s, lo, hi, rd);
   endtask
   task automatic conclude;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk);
      n_errors++;
      conclude();
   end
   initial begin
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rc(4'h0, 0, 0, "ctrl0");
      rc(4'h5, 16'hffff, 16'hffff, "period1");
      rc(4'he, 16'h4444, 16'h4444, "prio reg");
      cmp("prio port", 12'h924, 12'h924, irq_priority);
      bus(1'b1, 4'h1, 16'hffff);
      rc(4'h1, 16'ha072, 16'ha072, "ctrl1 bits");
      bus(1'b1, 4'h0, 16'h7fff);
      rc(4'h0, 16'h207a, 16'h207a, "ctrl0 bits");
      bus(1'b1, 4'hf, 16'h1234);
      rc(4'hf, 0, 0, "unmapped");
      bus(1'b1, 4'h0, 16'h0);
      bus(1'b1, 4'h1, 16'h0);
      $display("test registers done");
      idle_mode <= 1'b1;
      for (int p = 0; p < 4; p++) begin
         r = (p == 0) ? 1 : (p == 1) ? 8 : (p == 2) ? 64 : 256;
         bus(1'b1, 4'ha, 16'h0);
         bus(1'b1, 4'h2, 16'h8000 | 16'(p << 4));
         repeat (r * 20) @(posedge clk);
         bus(1'b1, 4'h2, 16'h0);
         rc(4'ha, (p == 0) ? 22 : 19, (p == 0) ? 24 : 21, "prescaled count");
      end
      v = rd;
      bus(1'b1, 4'h2, 16'ha000);
      repeat (20) @(posedge clk);
      rc(4'ha, v, v, "stop in idle");
      idle_mode <= 1'b0;
      $display("test prescale done");
      bus(1'b1, 4'h5, 16'h0004);
      bus(1'b1, 4'hd, 16'h0002);
      t0 = n_trig;
      bus(1'b1, 4'h1, 16'h8000);
      repeat (40) @(posedge clk);
      bus(1'b1, 4'h1, 16'h0);
      cmp("trigger 16", 7, 9, n_trig - t0);
      rc(4'h9, 0, 4, "count1");
      rc(4'hc, 16'h2, 16'h2, "flags 16");
      bus(1'b1, 4'he, 16'h4404);
      cmp("prio off port", 12'h904, 12'h904, irq_priority);
      // request register follows the new priority one edge later
      @(posedge clk);
      cmp("irq off", 0, 0, irq_request);
      bus(1'b1, 4'hc, 16'hf);
      rc(4'hc, 0, 0, "flags cleared");
      $display("test match done");
      bus(1'b1, 4'h8, 16'hfffc);
      bus(1'b1, 4'h9, 16'h0012);
      bus(1'b1, 4'h4, 16'h0002);
      bus(1'b1, 4'h5, 16'h0013);
      bus(1'b1, 4'h1, 16'h0030);
      bus(1'b1, 4'he, 16'h4470);
      t0 = n_trig;
      bus(1'b1, 4'h0, 16'h8008);
      repeat (20) @(posedge clk);
      bus(1'b1, 4'h0, 16'h0008);
      cmp("irq cascade", 4'h2, 4'h2, irq_request);
      cmp("trigger 32", 1, 1, n_trig - t0);
      rc(4'hc, 16'h2, 16'h2, "flags 32");
      rc(4'h9, 0, 0, "high word");
      rc(4'h8, 14, 18, "low word");
      bus(1'b1, 4'h8, 16'hfffe);
      bus(1'b1, 4'h9, 16'h0012);
      bus(1'b1, 4'h4, 16'hffff);
      bus(1'b1, 4'h5, 16'hffff);
      bus(1'b1, 4'h0, 16'h8008);
      bus(1'b1, 4'h0, 16'h0);
      rc(4'h9, 16'h13, 16'h13, "carry high");
      rc(4'h8, 1, 3, "carry low");
      bus(1'b1, 4'hc, 16'hf);
      $display("test cascade done");
      bus(1'b1, 4'hb, 16'h0);
      bus(1'b1, 4'h3, 16'h8002);
      for (int k = 0; k < 5; k++) begin
         pin[3] <= 1'b1;
         repeat (4) @(posedge clk);
         pin[3] <= 1'b0;
         repeat (4) @(posedge clk);
      end
      rc(4'hb, 5, 5, "external count");
      bus(1'b1, 4'h8, 16'h0);
      bus(1'b1, 4'h0, 16'h8040);
      repeat (20) @(posedge clk);
      rc(4'h8, 0, 0, "gate closed");
      pin[0] <= 1'b1;
      repeat (20) @(posedge clk);
      pin[0] <= 1'b0;
      repeat (4) @(posedge clk);
      rc(4'h8, 18, 24, "gate open");
      $display("test clock source done");
      t0 = n_trig;
      bus(1'b1, 4'h2, 16'h0);
      bus(1'b1, 4'ha, 16'h0);
      bus(1'b1, 4'hb, 16'h0);
      bus(1'b1, 4'h6, 16'h0001);
      bus(1'b1, 4'h7, 16'h0000);
      bus(1'b1, 4'hc, 16'hf);
      bus(1'b1, 4'h2, 16'h8008);
      repeat (10) @(posedge clk);
      bus(1'b1, 4'h2, 16'h0008);
      rc(4'hc, 16'h8, 16'h8, "flags pair2");
      cmp("trigger pair2", 0, 0, n_trig - t0);
      $display("test pair2 cascade done");
      conclude();
   end
endmodule
